// File: ptu_pkg.sv
// shared constants for the precision time stamp unit
package ptu_pkg;
	// geometry
	localparam int NUM_PORTS = 4;
	localparam int SRC_N     = 8;
	localparam int SEC_W     = 48;
	localparam int NS_W      = 30;
	localparam int TS_W      = 32;
	localparam int FIFO_D    = 16;
	localparam int FIFO_W    = 35;
	// stamp entry fields
	localparam int ENT_DIR   = 34;
	localparam int ENT_PORT  = 32;
	// synchroniser vector layout
	localparam int SY_RXF    = 0;
	localparam int SY_TXF    = 4;
	localparam int SY_RXP    = 8;
	localparam int SY_TXP    = 12;
	localparam int SY_RXV    = 16;
	localparam int SY_TXV    = 20;
	localparam int SY_RXE    = 24;
	localparam int SY_TXE    = 28;
	localparam int SY_GPIO   = 32;
	localparam int SY_W      = 33;
	// time base
	localparam int CLK_HZ          = 10_000_000;
	localparam int NS_PER_SEC_I    = 1_000_000_000;
	localparam logic [30:0] NS_WRAP = 31'h3b9aca00;
	localparam int CLK_NS          = NS_PER_SEC_I / CLK_HZ;
	localparam logic [8:0] NS_STEP = 9'(CLK_NS);
	// output pulse width, least time rounded up
	localparam int PULSE_NS        = 1000;
	localparam int PULSE_CYC_I     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] PULSE_CYC = 4'(PULSE_CYC_I < 1 ? 1 : PULSE_CYC_I);
	// reset values
	localparam logic [SEC_W-1:0] SEC_RST = 48'h0;
	localparam logic [NS_W-1:0]  NS_RST  = 30'h0;
	// compare sequencer
	typedef enum logic [2:0] {
		CMP_IDLE  = 3'b001,
		CMP_ARMED = 3'b010,
		CMP_PULSE = 3'b100
	} ptu_cmp_e;
endpackage : ptu_pkg

// File: ptu_top.sv
// time stamp unit: local time counter, events, gpio, port stamp engines
//
// Behaviour
// R01: only version 2 frames are stamped in standalone mode
// R02: every port stamps rx and tx, any role
// R03: 48-bit seconds, 30-bit ns single time source
// R04: target compare raises event and gpio events
// R05: gpio input captures or loads local time
// R06: gpio output driven by target compare event
// R07: four port engines plus one shared part
// R08: port rx/tx frame signals enter via synchronisers
// R09: time and event logic on the one clock
// R10: standalone mode stamps only classified ptp frames
// R11: header mode stamps every express frame, host uses headers
// R12: express frames stamped, preemptable fragments skipped
// R13: software loads time of day value
// R14: arrival stamps pushed into the stamp fifo
// R15: compact stamp is two zero bits, 30 ns
// R16: ns wraps at one billion, seconds increment
// R17: cross domain inputs pass two flip-flops
`timescale 1ns/1ns

// stamp fifo with registered output stage
module ptu_fifo #(
	parameter int W     = 35,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0]   count, next_count;
	logic          next_out_valid;
	logic [W-1:0]  next_out_data;
	logic          push, pop;

	// pointer and output stage next values
	always_comb begin
		in_ready       = (count != (AW+1)'(DEPTH));
		push           = in_valid && in_ready;
		pop            = (count != '0) && (!out_valid || out_ready);
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
		next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
		next_out_data  = pop ? mem[rd_ptr] : out_data;
	end

	// storage has no reset, control does
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
		if (rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end
endmodule : ptu_fifo

module ptu_top (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// port frame strobes from port clock domains
	input  wire logic [3:0]            rx_frame,
	input  wire logic [3:0]            tx_frame,
	input  wire logic [3:0]            rx_ptp,
	input  wire logic [3:0]            tx_ptp,
	input  wire logic [3:0]            rx_v2,
	input  wire logic [3:0]            tx_v2,
	input  wire logic [3:0]            rx_express,
	input  wire logic [3:0]            tx_express,
	// mode and time control
	input  wire logic                  standalone_mode,
	input  wire logic signed [7:0]     rate_trim,
	input  wire logic                  time_of_day_load,
	input  wire logic [47:0]           time_of_day_sec,
	input  wire logic [29:0]           time_of_day_ns,
	// target compare
	input  wire logic                  target_arm,
	input  wire logic [47:0]           target_sec,
	input  wire logic [29:0]           target_ns,
	// gpio pin and its setup
	input  wire logic                  gpio_is_output,
	input  wire logic                  gpio_load_mode,
	input  wire logic                  gpio_pin_in,
	output logic                       gpio_pin_out,
	output logic                       gpio_pin_oe_n,
	// time outputs
	output logic [47:0]                local_time_counter_sec,
	output logic [29:0]                local_time_counter_ns,
	output logic                       one_second_pulse,
	output logic                       event_pulse,
	output logic [47:0]                capture_sec,
	output logic [29:0]                capture_ns,
	output logic                       capture_valid,
	// stamp stream
	output logic                       ts_valid,
	input  wire logic                  ts_ready,
	output logic [31:0]                ts_data,
	output logic [1:0]                 ts_port,
	output logic                       ts_dir,
	output logic                       ts_drop
);
	// time at or past target compare
	function automatic logic time_ge(input logic [47:0] s, input logic [29:0] n,
		input logic [47:0] ts, input logic [29:0] tn);
		time_ge = (s > ts) || ((s == ts) && (n >= tn));
	endfunction : time_ge

	// frame qualifies for a stamp in the current mode
	function automatic logic stamp_ok(input logic ptp, input logic v2, input logic expr,
		input logic standalone);
		stamp_ok = expr && (!standalone || (ptp && v2)); // R01 R10 R11 R12
	endfunction : stamp_ok

	// synchronisers
	logic [ptu_pkg::SY_W-1:0] sy_a, sy_b, sy_prev;
	always_ff @(posedge clock) begin
		if (rst) begin
			sy_a    <= '0;
			sy_b    <= '0;
			sy_prev <= '0;
		end else begin
			sy_a    <= {gpio_pin_in, tx_express, rx_express, tx_v2, rx_v2,
				tx_ptp, rx_ptp, tx_frame, rx_frame}; // R08 R17
			sy_b    <= sy_a; // R17
			sy_prev <= sy_b;
		end
	end

	logic gpio_rise;
	assign gpio_rise = sy_b[ptu_pkg::SY_GPIO] && !sy_prev[ptu_pkg::SY_GPIO] && !gpio_is_output;

	// local time counter
	logic [47:0] next_sec;
	logic [29:0] next_ns;
	logic [30:0] ns_sum;
	logic [8:0]  ns_inc;
	logic        ns_wrap;
	logic [3:0]  pps_cnt, next_pps_cnt;
	logic        next_pps;
	logic [47:0] next_cap_sec;
	logic [29:0] next_cap_ns;
	logic        next_cap_valid;

	always_comb begin
		ns_inc  = ptu_pkg::NS_STEP + 9'(rate_trim); // tunable rate
		ns_sum  = {1'b0, local_time_counter_ns} + 31'(ns_inc);
		ns_wrap = ns_sum >= ptu_pkg::NS_WRAP;
		next_sec = local_time_counter_sec;
		next_ns  = ns_sum[29:0];
		if (ns_wrap) begin
			next_ns  = 30'(ns_sum - ptu_pkg::NS_WRAP); // R16
			next_sec = local_time_counter_sec + 48'h1; // R16
		end
		// load beats the tick; preset must already be below one billion
		if (time_of_day_load) begin
			next_sec = time_of_day_sec; // R13
			next_ns  = time_of_day_ns; // R13
		end else if (gpio_rise && gpio_load_mode) begin
			next_sec = time_of_day_sec; // R05
			next_ns  = time_of_day_ns; // R05
		end
		next_pps_cnt = ns_wrap ? ptu_pkg::PULSE_CYC :
			(pps_cnt != 4'h0 ? pps_cnt - 4'h1 : 4'h0);
		next_pps     = next_pps_cnt != 4'h0;
		next_cap_valid = gpio_rise && !gpio_load_mode; // R05
		next_cap_sec   = next_cap_valid ? local_time_counter_sec : capture_sec;
		next_cap_ns    = next_cap_valid ? local_time_counter_ns : capture_ns;
	end

	// one time source for every stamp and event
	always_ff @(posedge clock) begin
		if (rst) begin
			local_time_counter_sec <= ptu_pkg::SEC_RST; // R03
			local_time_counter_ns  <= ptu_pkg::NS_RST; // R03
			pps_cnt                <= 4'h0;
			one_second_pulse       <= 1'b0;
			capture_sec            <= 48'h0;
			capture_ns             <= 30'h0;
			capture_valid          <= 1'b0;
		end else begin
			local_time_counter_sec <= next_sec; // R09
			local_time_counter_ns  <= next_ns;
			pps_cnt                <= next_pps_cnt;
			one_second_pulse       <= next_pps;
			capture_sec            <= next_cap_sec;
			capture_ns             <= next_cap_ns;
			capture_valid          <= next_cap_valid;
		end
	end

	// target compare sequencer
	ptu_pkg::ptu_cmp_e cmp_state, next_cmp_state;
	logic [3:0] cmp_cnt, next_cmp_cnt;
	logic       next_event, next_gpio_out, next_oe_n;

	always_comb begin
		next_cmp_state = cmp_state;
		next_cmp_cnt   = cmp_cnt;
		next_event     = 1'b0;
		case (cmp_state)
			ptu_pkg::CMP_IDLE: begin
				if (target_arm) begin
					next_cmp_state = ptu_pkg::CMP_ARMED;
				end
			end
			ptu_pkg::CMP_ARMED: begin
				if (time_ge(local_time_counter_sec, local_time_counter_ns,
					target_sec, target_ns)) begin
					next_cmp_state = ptu_pkg::CMP_PULSE; // R04
					next_cmp_cnt   = ptu_pkg::PULSE_CYC;
					next_event     = 1'b1; // R04
				end
			end
			ptu_pkg::CMP_PULSE: begin
				next_cmp_cnt = cmp_cnt - 4'h1;
				if (cmp_cnt == 4'h1) begin
					next_cmp_state = ptu_pkg::CMP_IDLE;
				end
			end
			default: begin
				next_cmp_state = ptu_pkg::CMP_IDLE;
			end
		endcase
		// pin drives the compare pulse only while set as output
		next_gpio_out = gpio_is_output && (next_cmp_state == ptu_pkg::CMP_PULSE); // R06
		next_oe_n     = !gpio_is_output;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cmp_state     <= ptu_pkg::CMP_IDLE;
			cmp_cnt       <= 4'h0;
			event_pulse   <= 1'b0;
			gpio_pin_out  <= 1'b0;
			gpio_pin_oe_n <= 1'b1;
		end else begin
			cmp_state     <= next_cmp_state;
			cmp_cnt       <= next_cmp_cnt;
			event_pulse   <= next_event;
			gpio_pin_out  <= next_gpio_out;
			gpio_pin_oe_n <= next_oe_n;
		end
	end

	// stamp engines: sources 0-3 rx ports, 4-7 tx ports
	logic [ptu_pkg::SRC_N-1:0] pend, next_pend, hit;
	logic [31:0] stamp [0:ptu_pkg::SRC_N-1];
	logic [31:0] next_stamp [0:ptu_pkg::SRC_N-1];
	logic        next_drop;
	logic        push_valid, push_ready;
	logic [2:0]  pick;
	logic [ptu_pkg::FIFO_W-1:0] push_data, fifo_out;

	always_comb begin
		hit       = '0;
		next_drop = 1'b0;
		pick      = 3'h0;
		for (int p = 0; p < ptu_pkg::NUM_PORTS; p++) begin
			hit[p] = sy_b[ptu_pkg::SY_RXF+p] && !sy_prev[ptu_pkg::SY_RXF+p] &&
				stamp_ok(sy_b[ptu_pkg::SY_RXP+p], sy_b[ptu_pkg::SY_RXV+p],
				sy_b[ptu_pkg::SY_RXE+p], standalone_mode); // R02 R07 R14
			hit[p+4] = sy_b[ptu_pkg::SY_TXF+p] && !sy_prev[ptu_pkg::SY_TXF+p] &&
				stamp_ok(sy_b[ptu_pkg::SY_TXP+p], sy_b[ptu_pkg::SY_TXV+p],
				sy_b[ptu_pkg::SY_TXE+p], standalone_mode); // R02 R07
		end
		// lowest pending source goes first
		for (int i = ptu_pkg::SRC_N - 1; i >= 0; i--) begin
			if (pend[i]) begin
				pick = 3'(i);
			end
		end
		push_valid = pend != '0;
		push_data  = {pick, stamp[pick]};
		next_pend  = pend;
		if (push_valid && push_ready) begin
			next_pend[pick] = 1'b0;
		end
		for (int i = 0; i < ptu_pkg::SRC_N; i++) begin
			next_stamp[i] = stamp[i];
			if (hit[i]) begin
				// a stamp still waiting is kept; the newer one is lost
				if (pend[i] && !(push_valid && push_ready && pick == 3'(i))) begin
					next_drop = 1'b1;
				end else begin
					next_pend[i]  = 1'b1; // set wins over push clear
					next_stamp[i] = {2'b00, local_time_counter_ns}; // R15
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pend    <= '0;
			ts_drop <= 1'b0;
			for (int i = 0; i < ptu_pkg::SRC_N; i++) begin
				stamp[i] <= 32'h0;
			end
		end else begin
			pend    <= next_pend;
			ts_drop <= next_drop;
			for (int i = 0; i < ptu_pkg::SRC_N; i++) begin
				stamp[i] <= next_stamp[i];
			end
		end
	end

	// host stalls via ts_ready, which backs up into the pending flags
	ptu_fifo #(
		.W     (ptu_pkg::FIFO_W),
		.DEPTH (ptu_pkg::FIFO_D)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (ts_valid),
		.out_ready (ts_ready),
		.out_data  (fifo_out)
	); // R14

	assign ts_data = fifo_out[31:0];
	assign ts_port = fifo_out[ptu_pkg::ENT_PORT+1:ptu_pkg::ENT_PORT];
	assign ts_dir  = fifo_out[ptu_pkg::ENT_DIR];
endmodule : ptu_top

// File: ptu_checker.sv
// assertion checker on the time stamp unit ports
`timescale 1ns/1ns
module ptu_checker (
	// clock and reset
	input wire logic              clock,
	input wire logic              rst,
	// time control seen by the unit
	input wire logic              time_of_day_load,
	input wire logic              gpio_load_mode,
	input wire logic              gpio_is_output,
	input wire logic signed [7:0] rate_trim,
	input wire logic [47:0]       time_of_day_sec,
	input wire logic [29:0]       time_of_day_ns,
	input wire logic [47:0]       target_sec,
	input wire logic [29:0]       target_ns,
	// outputs under watch
	input wire logic [47:0]       local_time_counter_sec,
	input wire logic [29:0]       local_time_counter_ns,
	input wire logic              one_second_pulse,
	input wire logic              event_pulse,
	input wire logic              gpio_pin_out,
	input wire logic              gpio_pin_oe_n,
	input wire logic              capture_valid,
	input wire logic              ts_valid,
	input wire logic              ts_ready,
	input wire logic [31:0]       ts_data,
	input wire logic [1:0]        ts_port,
	input wire logic              ts_drop
);
	// next ns before the wrap test; quiet means no load can win
	logic [31:0] sum;
	logic        quiet;
	assign sum = {2'h0, local_time_counter_ns} + 32'h64 + 32'(rate_trim);
	assign quiet = !time_of_day_load && !gpio_load_mode;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_tod_load: assert property (time_of_day_load |=>
		local_time_counter_sec == $past(time_of_day_sec) &&
		local_time_counter_ns == $past(time_of_day_ns)) else $error("time load wrong");
	a_ns_step: assert property (quiet |=> local_time_counter_ns == 30'(
		$past(sum) >= 32'h3b9aca00 ? $past(sum) - 32'h3b9aca00 : $past(sum)))
		else $error("ns step wrong");
	a_sec_wrap: assert property (quiet && sum >= 32'h3b9aca00 |=>
		local_time_counter_sec == $past(local_time_counter_sec) + 48'h1)
		else $error("seconds carry wrong");
	a_pulse_len: assert property ($rose(one_second_pulse) |->
		one_second_pulse[*8] ##1 one_second_pulse[*2] ##1 !one_second_pulse)
		else $error("second pulse width wrong");
	a_event_cause: assert property (event_pulse |->
		{$past(local_time_counter_sec), $past(local_time_counter_ns)} >=
		{$past(target_sec), $past(target_ns)}) else $error("event before target");
	a_event_once: assert property (event_pulse |=> !event_pulse)
		else $error("event longer than one cycle");
	a_gpio_pulse: assert property ($rose(event_pulse) && !gpio_pin_oe_n |->
		gpio_pin_out[*8] ##1 gpio_pin_out[*2] ##1 !gpio_pin_out)
		else $error("gpio pulse wrong");
	a_oe_follow: assert property (!$past(rst) |-> gpio_pin_oe_n == !$past(gpio_is_output))
		else $error("pin enable wrong");
	a_cap_input: assert property (capture_valid |-> gpio_pin_oe_n)
		else $error("capture while pin drives");
	a_ts_hold: assert property (ts_valid && !ts_ready |=>
		ts_valid && $stable(ts_data) && $stable(ts_port)) else $error("stamp not held");
	a_ts_upper: assert property (ts_valid |-> ts_data[31:30] == 2'h0)
		else $error("stamp upper bits set");
	// main scenarios reached
	c_event: cover property (event_pulse);
	c_capture: cover property (capture_valid);
	c_stall: cover property (ts_valid && !ts_ready ##1 ts_valid && ts_ready);
	c_drop: cover property (ts_drop);
endmodule : ptu_checker

// File: ptu_host.sv
// stamp stream host that takes stamps and stalls on request
`timescale 1ns/1ns
module ptu_host (
	// clock
	input wire logic        clock,
	// stall request from the bench
	input wire logic        stall,
	// stamp stream
	input wire logic        ts_valid,
	output logic            ts_ready,
	input wire logic [31:0] ts_data,
	input wire logic [1:0]  ts_port,
	input wire logic        ts_dir
);
	// accepted stamps as dir, port, ns
	logic [34:0] got[$];
	initial ts_ready = 1'b0;
	// take on the agreeing edge, ready moves only after it
	always @(posedge clock) begin
		if (ts_valid && ts_ready)
			got.push_back({ts_dir, ts_port, ts_data});
		ts_ready <= !stall;
	end
endmodule : ptu_host

// File: ptu_top_test.sv
// self-checking bench for the time stamp unit
`timescale 1ns/1ns
module ptu_top_test;
	// stimulus, observed outputs and bookkeeping
	logic              clock = 1'b0, rst = 1'b1, pin_drv = 1'b0, stall = 1'b1;
	logic [7:0]        frm = 8'h00, ptp = 8'h00, ver = 8'h00, xpr = 8'h00;
	logic              standalone_mode = 1'b0, time_of_day_load = 1'b0, target_arm = 1'b0;
	logic signed [7:0] rate_trim = 8'sh00;
	logic [47:0]       time_of_day_sec = 48'h0, target_sec = 48'h0, local_time_counter_sec, capture_sec;
	logic [29:0]       time_of_day_ns = 30'h0, target_ns = 30'h0, local_time_counter_ns, capture_ns, v;
	logic              gpio_is_output = 1'b1, gpio_load_mode = 1'b0, gpio_pin_out, gpio_pin_oe_n;
	logic              one_second_pulse, event_pulse, capture_valid, ts_valid, ts_ready, ts_dir, ts_drop;
	logic [31:0]       ts_data;
	logic [1:0]        ts_port;
	int                failures = 0, checked = 0, cycles = 0, n, k, w;
	int                osp_n = 0, gpio_n = 0, drop_n = 0, ev_n = 0;
	// pin level: the unit drives while its enable is low
	wire gpio_pin_in = gpio_pin_oe_n ? pin_drv : gpio_pin_out;
	always #50 clock = ~clock;
	ptu_top dut (.clock, .rst, .rx_frame(frm[3:0]), .tx_frame(frm[7:4]), .rx_ptp(ptp[3:0]),
		.tx_ptp(ptp[7:4]), .rx_v2(ver[3:0]), .tx_v2(ver[7:4]), .rx_express(xpr[3:0]),
		.tx_express(xpr[7:4]), .standalone_mode, .rate_trim, .time_of_day_load,
		.time_of_day_sec, .time_of_day_ns, .target_arm, .target_sec, .target_ns,
		.gpio_is_output, .gpio_load_mode, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_n,
		.local_time_counter_sec, .local_time_counter_ns, .one_second_pulse, .event_pulse,
		.capture_sec, .capture_ns, .capture_valid, .ts_valid, .ts_ready, .ts_data, .ts_port,
		.ts_dir, .ts_drop);
	ptu_host host (.clock, .stall, .ts_valid, .ts_ready, .ts_data, .ts_port, .ts_dir);
	// pulse tallies, non-blocking so a same-edge read sees the old sum
	always @(negedge clock) begin
		osp_n <= osp_n + one_second_pulse;
		gpio_n <= gpio_n + gpio_pin_out;
		drop_n <= drop_n + ts_drop;
		ev_n <= ev_n + event_pulse;
	end
	// cycle ceiling cuts a hang short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures = failures + 1;
			conclude();
		end
	end
	task check(input string what, input logic [47:0] exp, input logic [47:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task load(input logic [47:0] s, input logic [29:0] ns);
		@(posedge clock);
		time_of_day_sec <= s;
		time_of_day_ns <= ns;
		time_of_day_load <= 1'b1;
		@(posedge clock);
		time_of_day_load <= 1'b0;
	endtask : load
	task pulse(input int b);
		@(posedge clock) frm[b] <= 1'b1;
		repeat (4) @(posedge clock);
		frm[b] <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : pulse
	task t_time;
		load(48'h12, 30'h3b9ac96a);
		@(negedge clock) check("load ns", 48'h3b9ac96a, local_time_counter_ns);
		@(negedge clock) check("tick ns", 48'h3b9ac9ce, local_time_counter_ns);
		@(negedge clock) check("wrap ns", 48'h32, local_time_counter_ns);
		check("wrap sec", 48'h13, local_time_counter_sec);
		n = osp_n;
		repeat (14) @(negedge clock);
		check("second pulse", 48'ha, 48'(osp_n - n));
		@(posedge clock) rate_trim <= -8'sh0a;
		@(negedge clock) v = local_time_counter_ns;
		@(negedge clock) check("trim step", 48'(v + 30'h5a), local_time_counter_ns);
		@(posedge clock) rate_trim <= 8'sh00;
		$display("test time done");
	endtask : t_time
	task t_cmp;
		@(posedge clock);
		target_sec <= 48'h20;
		target_ns <= 30'h3e8;
		load(48'h20, 30'h0);
		n = ev_n;
		@(posedge clock) target_arm <= 1'b1;
		@(posedge clock) target_arm <= 1'b0;
		w = 0;
		while (event_pulse !== 1'b1 && w < 40) @(negedge clock) w++;
		check("event ns", 48'h44c, local_time_counter_ns);
		k = gpio_n;
		// arming while the pulse runs is ignored
		@(posedge clock) target_arm <= 1'b1;
		@(posedge clock) target_arm <= 1'b0;
		repeat (15) @(negedge clock);
		check("gpio pulse", 48'ha, 48'(gpio_n - k));
		check("events", 48'h1, 48'(ev_n - n));
		@(posedge clock) target_arm <= 1'b1;
		@(posedge clock) target_arm <= 1'b0;
		repeat (5) @(negedge clock);
		check("rearm event", 48'h2, 48'(ev_n - n));
		repeat (12) @(posedge clock);
		$display("test compare done");
	endtask : t_cmp
	task t_gpio;
		@(posedge clock) gpio_is_output <= 1'b0;
		load(48'h30, 30'h0);
		@(posedge clock) pin_drv <= 1'b1;
		w = 0;
		while (capture_valid !== 1'b1 && w < 10) @(negedge clock) w++;
		check("capture sec", 48'h30, capture_sec);
		check("capture ns", 48'h12c, 48'(capture_ns));
		check("pin released", 48'h1, 48'(gpio_pin_oe_n));
		@(posedge clock);
		pin_drv <= 1'b0;
		gpio_load_mode <= 1'b1;
		time_of_day_sec <= 48'h77;
		repeat (4) @(posedge clock);
		pin_drv <= 1'b1;
		repeat (6) @(posedge clock);
		@(negedge clock) check("gpio load sec", 48'h77, local_time_counter_sec);
		@(posedge clock);
		pin_drv <= 1'b0;
		gpio_load_mode <= 1'b0;
		gpio_is_output <= 1'b1;
		$display("test gpio done");
	endtask : t_gpio
	task t_qual;
		@(posedge clock);
		xpr <= 8'hfb;
		ptp <= 8'h90;
		ver <= 8'h81;
		// header mode: rx1 express, rx2 a fragment
		pulse(1);
		pulse(2);
		@(posedge clock) standalone_mode <= 1'b1;
		pulse(7);
		pulse(4);
		pulse(0);
		@(posedge clock);
		standalone_mode <= 1'b0;
		stall <= 1'b0;
		repeat (10) @(posedge clock);
		check("stamp count", 48'h2, 48'(host.got.size()));
		check("first stamp", 48'h1, 48'(host.got[0][34:32]));
		check("second stamp", 48'h7, 48'(host.got[1][34:32]));
		check("stamp spacing", 48'h76c, 48'(host.got[1][29:0] - host.got[0][29:0]));
		check("stamp upper", 48'h0, 48'({host.got[0][31:30], host.got[1][31:30]}));
		host.got.delete();
		$display("test qualify done");
	endtask : t_qual
	task t_fill;
		@(posedge clock) stall <= 1'b1;
		n = drop_n;
		k = 0;
		while (drop_n == n && k < 25) begin
			pulse(0);
			k++;
		end
		check("drop seen", 48'h1, 48'(drop_n - n));
		check("capacity", 48'h13, 48'(k));
		@(posedge clock) stall <= 1'b0;
		repeat (40) @(posedge clock);
		check("drained", 48'(k - 1), 48'(host.got.size()));
		@(negedge clock) check("empty", 48'h0, 48'(ts_valid));
		$display("test fill done");
	endtask : t_fill
	task conclude;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_time;
		t_cmp;
		t_gpio;
		t_qual;
		t_fill;
		conclude();
	end
endmodule : ptu_top_test
bind ptu_top ptu_checker chk (.clock, .rst, .time_of_day_load, .gpio_load_mode, .gpio_is_output,
	.rate_trim, .time_of_day_sec, .time_of_day_ns, .target_sec, .target_ns,
	.local_time_counter_sec, .local_time_counter_ns, .one_second_pulse, .event_pulse,
	.gpio_pin_out, .gpio_pin_oe_n, .capture_valid, .ts_valid, .ts_ready, .ts_data, .ts_port,
	.ts_drop);
